// ### logic/rtc_consts.vh
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
// ***************************************************
// register offsets on the byte-wide register port
// ***************************************************
`define RTC_OFS_CONFIG 8'ha1
`define RTC_OFS_SUBSEC 8'ha2
`define RTC_OFS_SEC 8'ha3
`define RTC_OFS_MIN 8'ha4
`define RTC_OFS_HOUR 8'ha5
`define RTC_OFS_ALARM_INTERVAL_VALUE 8'ha6
`define RTC_OFS_KEY 8'hc1
`define RTC_OFS_NOMTRIM 8'hf6
`define RTC_OFS_THERMTRIM 8'hf7
`define RTC_OFS_IRQCFG 8'hff
// ***************************************************
// rtc_config field positions
// ***************************************************
`define RTC_CFG_MIDNIGHT 7
`define RTC_CFG_DAYWRAP 6
`define RTC_CFG_ITS_HI 5
`define RTC_CFG_ITS_LO 4
`define RTC_CFG_SINGLE 3
`define RTC_CFG_ALARM 2
`define RTC_CFG_ITEN 1
`define RTC_CFG_RSVD 0
// ***************************************************
// values
// ***************************************************
`define RTC_KEY_UNLOCK 8'hea
`define RTC_KEY_RESET 8'h00
`define RTC_CNT_RESET 8'h00
`define RTC_SUBSEC_MAX 8'h7f
`define RTC_SEC_MAX 8'h3b
`define RTC_MIN_MAX 8'h3b
`define RTC_HOUR_MAX_24 8'h17
`define RTC_HOUR_MAX_256 8'hff
`define RTC_TB_SUBSEC 2'h0
`define RTC_TB_SEC 2'h1
`define RTC_TB_MIN 2'h2
`define RTC_TB_HOUR 2'h3
// ***************************************************
// timing: crystal edges per 128 hz tick, minus one
// ***************************************************
`define RTC_PRESCALE_LAST 10'h0ff
`endif

// ### logic/rtc_prescale.v
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"
// ***************************************************
// crystal prescaler: 256 crystal edges per 128 hz tick
// ***************************************************
module rtc_prescale (
  // clock and power-on reset
  input wire ref_clk_i,
  input wire resetn_i,
  // crystal and calibration
  input wire xtal_i,
  input wire [8:0] corr_i,
  input wire sec_last_i,
  // tick
  output reg tick_o
);
  reg xtal_prev_q;
  reg [9:0] cnt_q;
  wire xtal_rise;
  wire [9:0] term;

  assign xtal_rise = xtal_i & ~xtal_prev_q;
  // correction only stretches or shrinks the last period of each second, so the
  // sub-second ticks stay even and a whole second carries the full trim
  assign term = sec_last_i ? (`RTC_PRESCALE_LAST - {corr_i[8], corr_i}) : `RTC_PRESCALE_LAST;

  // edge counter runs on crystal edges only, never on the core rate
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xtal_prev_q <= 1'b0;
      cnt_q <= 10'h000;
      tick_o <= 1'b0;
    end else begin
      xtal_prev_q <= xtal_i;
      tick_o <= 1'b0;
      if (xtal_rise) begin
        // >= guards against a trim change that lands below the running count
        if (cnt_q >= term) begin
          cnt_q <= 10'h000;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 10'h001;
        end
      end
    end
  end
endmodule // rtc_prescale
`default_nettype wire

// ### logic/rtc_timekeeper.v
// Behaviour
// - counting is driven by crystal edges, not the core clock
// - nominal and thermal trims together correct the tick rate
// - counters run whatever power mode the chip is in
// - counters survive watchdog and pin resets; only power-on reset clears them
// - registers are written and read only as whole bytes
// - protected counters and irq config accept writes only while key holds unlock value
// - midnight flag bit 7 sets when counters roll to all zeros
// - midnight flag stays set until software writes it clear
// - set midnight flag blocks re-entry to deep sleep
// - day-wrap select survives warm resets, cleared by power-on reset
// - hours wrap at 255 with day-wrap 0, at 23 with day-wrap 1
// - sub-second counter wraps 127 to 0 and carries into seconds
// - seconds and minutes wrap 59 to 0 and carry onward
// - repeating mode sets alarm after programmed ticks, then restarts
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"
module rtc_timekeeper (
  // clock and power-on reset
  input wire ref_clk_i,
  input wire resetn_i,
  // warm reset (watchdog or reset pin), one-cycle pulse
  input wire warm_rst_i,
  // crystal
  input wire xtal_i,
  // register port
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_we_i,
  output reg [7:0] sfr_rdata_o,
  // status and side outputs
  output reg midnight_o,
  output reg alarm_o,
  output reg deep_sleep_block_o,
  output reg [7:0] irq_pin_config_o
);
  // ***************************************************
  // state
  // ***************************************************
  reg [7:0] sub_q;
  reg [7:0] sec_q;
  reg [7:0] min_q;
  reg [7:0] hour_q;
  reg day_wrap_q;
  reg midnight_q;
  reg [1:0] its_q;
  reg single_q;
  reg alarm_q;
  reg iten_q;
  reg [7:0] alarm_interval_value_q;
  reg [7:0] icount_q;
  reg idone_q;
  reg [7:0] key_q;
  reg [7:0] nom_trim_q;
  reg [7:0] therm_trim_q;
  reg [7:0] irqcfg_q;

  wire tick;
  wire unlocked;
  wire wr_cfg;
  wire [8:0] corr;
  wire sub_wrap;
  wire sec_wrap;
  wire min_wrap;
  wire hour_wrap;
  wire [7:0] hour_max;
  reg tb_pulse;

  // next value of a wrapping counter
  function [7:0] inc_wrap;
    input [7:0] val;
    input [7:0] max;
    begin
      inc_wrap = (val == max) ? `RTC_CNT_RESET : val + 8'h01;
    end
  endfunction

  // ***************************************************
  // prescaler
  // ***************************************************
  assign corr = {nom_trim_q[7], nom_trim_q} + {therm_trim_q[7], therm_trim_q};

  rtc_prescale u_prescale (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .xtal_i(xtal_i),
    .corr_i(corr),
    .sec_last_i(sub_q == `RTC_SUBSEC_MAX),
    .tick_o(tick)
  );

  // ***************************************************
  // carry chain
  // ***************************************************
  // no power-mode input gates the chain, so it keeps time in every mode
  assign sub_wrap = tick & (sub_q == `RTC_SUBSEC_MAX);
  assign sec_wrap = sub_wrap & (sec_q == `RTC_SEC_MAX);
  assign min_wrap = sec_wrap & (min_q == `RTC_MIN_MAX);
  assign hour_max = day_wrap_q ? `RTC_HOUR_MAX_24 : `RTC_HOUR_MAX_256;
  assign hour_wrap = min_wrap & (hour_q == hour_max);

  // key compare: only the unlock value opens the protected set
  assign unlocked = (key_q == `RTC_KEY_UNLOCK);
  assign wr_cfg = sfr_we_i & (sfr_addr_i == `RTC_OFS_CONFIG);

  // timebase select for the interval timer
  always @* begin
    case (its_q)
      `RTC_TB_SUBSEC: tb_pulse = tick;
      `RTC_TB_SEC: tb_pulse = sub_wrap;
      `RTC_TB_MIN: tb_pulse = sec_wrap;
      `RTC_TB_HOUR: tb_pulse = min_wrap;
      default: tb_pulse = 1'b0;
    endcase
  end

  // ***************************************************
  // timekeeping counters: power-on reset only
  // ***************************************************
  // a protected write in the same cycle as a tick wins, so software sets an exact time
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sub_q <= `RTC_CNT_RESET;
      sec_q <= `RTC_CNT_RESET;
      min_q <= `RTC_CNT_RESET;
      hour_q <= `RTC_CNT_RESET;
      irqcfg_q <= `RTC_CNT_RESET;
    end else begin
      if (tick) begin
        sub_q <= inc_wrap(sub_q, `RTC_SUBSEC_MAX);
      end
      if (sub_wrap) begin
        sec_q <= inc_wrap(sec_q, `RTC_SEC_MAX);
      end
      if (sec_wrap) begin
        min_q <= inc_wrap(min_q, `RTC_MIN_MAX);
      end
      if (min_wrap) begin
        hour_q <= inc_wrap(hour_q, hour_max);
      end
      // whole-byte writes only; a locked key drops the write silently
      if (sfr_we_i && unlocked) begin
        case (sfr_addr_i)
          `RTC_OFS_SUBSEC: sub_q <= sfr_wdata_i;
          `RTC_OFS_SEC: sec_q <= sfr_wdata_i;
          `RTC_OFS_MIN: min_q <= sfr_wdata_i;
          `RTC_OFS_HOUR: hour_q <= sfr_wdata_i;
          `RTC_OFS_IRQCFG: irqcfg_q <= sfr_wdata_i;
          default: irqcfg_q <= irqcfg_q;
        endcase
      end
    end
  end

  // ***************************************************
  // retained config bits: day-wrap and midnight flag
  // ***************************************************
  // midnight clears on a written 0, but a rollover in the same cycle wins
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      day_wrap_q <= 1'b0;
      midnight_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        day_wrap_q <= sfr_wdata_i[`RTC_CFG_DAYWRAP];
      end
      if (hour_wrap) begin
        midnight_q <= 1'b1;
      end else if (wr_cfg && !sfr_wdata_i[`RTC_CFG_MIDNIGHT]) begin
        midnight_q <= 1'b0;
      end
    end
  end

  // ***************************************************
  // warm-resettable registers, interval timer, and trims that only power-on reset clears
  // ***************************************************
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      its_q <= 2'h0;
      single_q <= 1'b0;
      alarm_q <= 1'b0;
      iten_q <= 1'b0;
      alarm_interval_value_q <= 8'h00;
      icount_q <= 8'h00;
      idone_q <= 1'b0;
      key_q <= `RTC_KEY_RESET;
      nom_trim_q <= 8'h00;
      therm_trim_q <= 8'h00;
    end else if (warm_rst_i) begin
      its_q <= 2'h0;
      single_q <= 1'b0;
      alarm_q <= 1'b0;
      iten_q <= 1'b0;
      alarm_interval_value_q <= 8'h00;
      icount_q <= 8'h00;
      idone_q <= 1'b0;
      key_q <= `RTC_KEY_RESET; // warm reset relocks, limiting runaway code
    end else begin
      if (sfr_we_i) begin
        case (sfr_addr_i)
          `RTC_OFS_CONFIG: begin
            its_q <= sfr_wdata_i[`RTC_CFG_ITS_HI:`RTC_CFG_ITS_LO];
            single_q <= sfr_wdata_i[`RTC_CFG_SINGLE];
            iten_q <= sfr_wdata_i[`RTC_CFG_ITEN];
          end
          `RTC_OFS_ALARM_INTERVAL_VALUE: alarm_interval_value_q <= sfr_wdata_i;
          `RTC_OFS_KEY: key_q <= sfr_wdata_i;
          `RTC_OFS_NOMTRIM: nom_trim_q <= sfr_wdata_i;
          `RTC_OFS_THERMTRIM: therm_trim_q <= sfr_wdata_i;
          default: key_q <= key_q;
        endcase
      end
      // disabled timer holds its count at zero and rearms single shot
      if (!iten_q) begin
        icount_q <= 8'h00;
        idone_q <= 1'b0;
      end else if (tb_pulse && !idone_q) begin
        if (icount_q + 8'h01 >= alarm_interval_value_q) begin
          icount_q <= 8'h00;
          idone_q <= single_q;
        end else begin
          icount_q <= icount_q + 8'h01;
        end
      end
      // alarm: set wins over a written 0; user code cannot set it
      if (iten_q && tb_pulse && !idone_q && (icount_q + 8'h01 >= alarm_interval_value_q)) begin
        alarm_q <= 1'b1;
      end else if (wr_cfg && !sfr_wdata_i[`RTC_CFG_ALARM]) begin
        alarm_q <= 1'b0;
      end
    end
  end

  // ***************************************************
  // read data and outputs, all registered
  // ***************************************************
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sfr_rdata_o <= 8'h00;
      midnight_o <= 1'b0;
      alarm_o <= 1'b0;
      deep_sleep_block_o <= 1'b0;
      irq_pin_config_o <= 8'h00;
    end else begin
      case (sfr_addr_i)
        `RTC_OFS_CONFIG: sfr_rdata_o <= {midnight_q, day_wrap_q, its_q, single_q, alarm_q, iten_q, 1'b1};
        `RTC_OFS_SUBSEC: sfr_rdata_o <= sub_q;
        `RTC_OFS_SEC: sfr_rdata_o <= sec_q;
        `RTC_OFS_MIN: sfr_rdata_o <= min_q;
        `RTC_OFS_HOUR: sfr_rdata_o <= hour_q;
        `RTC_OFS_ALARM_INTERVAL_VALUE: sfr_rdata_o <= alarm_interval_value_q;
        `RTC_OFS_KEY: sfr_rdata_o <= key_q;
        `RTC_OFS_NOMTRIM: sfr_rdata_o <= nom_trim_q;
        `RTC_OFS_THERMTRIM: sfr_rdata_o <= therm_trim_q;
        `RTC_OFS_IRQCFG: sfr_rdata_o <= irqcfg_q;
        default: sfr_rdata_o <= 8'h00;
      endcase
      midnight_o <= midnight_q;
      alarm_o <= alarm_q;
      deep_sleep_block_o <= midnight_q;
      irq_pin_config_o <= irqcfg_q;
    end
  end
endmodule // rtc_timekeeper
`default_nettype wire

// ### test/rtc_timekeeper_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// port-level checks of the timekeeper
// ***************************************************
module rtc_timekeeper_sva (
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic warm_rst_i,
  input wire logic xtal_i,
  // register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_we_i,
  input wire logic [7:0] sfr_rdata_o,
  // status outputs
  input wire logic midnight_o,
  input wire logic alarm_o,
  input wire logic deep_sleep_block_o,
  input wire logic [7:0] irq_pin_config_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // flag-clearing config writes; set wins, so a clear is only trusted two edges on
  wire logic clr_mid = sfr_we_i && sfr_addr_i == 8'ha1 && !sfr_wdata_i[7];
  wire logic clr_alm = sfr_we_i && sfr_addr_i == 8'ha1 && !sfr_wdata_i[2];
  // port-side mirror of the key: only the unlock value opens, warm reset relocks
  logic key_open_q;
  wire logic wr_irq_ok = sfr_we_i && sfr_addr_i == 8'hff && key_open_q;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_open_q <= 1'b0;
    end else if (warm_rst_i) begin
      key_open_q <= 1'b0;
    end else if (sfr_we_i && sfr_addr_i == 8'hc1) begin
      key_open_q <= (sfr_wdata_i == 8'hea);
    end
  end
  a_unmapped_read_zero: assert property (!(sfr_addr_i inside {8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6,
    8'hc1, 8'hf6, 8'hf7, 8'hff}) |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_cfg_bit0_one: assert property (sfr_addr_i == 8'ha1 |=> sfr_rdata_o[0]) else $error("config bit0 low");
  a_sleep_block_follows: assert property (deep_sleep_block_o == midnight_o)
    else $error("sleep block differs from midnight");
  a_midnight_clear: assert property (clr_mid |-> ##2 !midnight_o) else $error("midnight not cleared");
  a_midnight_sticky: assert property (midnight_o && !clr_mid && !$past(clr_mid) |=> midnight_o)
    else $error("midnight dropped without clear");
  a_irq_cfg_guarded: assert property ($changed(irq_pin_config_o) |-> $past(wr_irq_ok, 2))
    else $error("irq config changed without write");
  a_alarm_sticky: assert property (alarm_o && !clr_alm && !$past(clr_alm) && !warm_rst_i && !$past(warm_rst_i)
    |=> alarm_o) else $error("alarm dropped without clear");
  a_warm_clears_alarm: assert property (warm_rst_i |-> ##2 !alarm_o) else $error("alarm survived warm reset");
endmodule // rtc_timekeeper_sva
bind rtc_timekeeper rtc_timekeeper_sva i_rtc_timekeeper_sva (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .warm_rst_i(warm_rst_i), .xtal_i(xtal_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_we_i(sfr_we_i), .sfr_rdata_o(sfr_rdata_o), .midnight_o(midnight_o), .alarm_o(alarm_o),
  .deep_sleep_block_o(deep_sleep_block_o), .irq_pin_config_o(irq_pin_config_o));
`default_nettype wire

// ### test/rtc_timekeeper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeper_tb;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic warm_rst_i = 1'b0;
  logic xtal_i;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_we_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic midnight_o;
  logic alarm_o;
  logic deep_sleep_block_o;
  logic [7:0] irq_pin_config_o;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int last_wait = 0;
  // ***************************************************
  // clock, crystal and design
  // ***************************************************
  always #10 ref_clk_i = ~ref_clk_i;
  rtc_xtal_model i_rtc_xtal_model (.ref_clk_i(ref_clk_i), .run_i(resetn_i), .xtal_o(xtal_i));
  rtc_timekeeper i_rtc_timekeeper (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .warm_rst_i(warm_rst_i),
    .xtal_i(xtal_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_we_i(sfr_we_i),
    .sfr_rdata_o(sfr_rdata_o), .midnight_o(midnight_o), .alarm_o(alarm_o),
    .deep_sleep_block_o(deep_sleep_block_o), .irq_pin_config_o(irq_pin_config_o));
  // ***************************************************
  // access and compare tasks
  // ***************************************************
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_we_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    @(posedge ref_clk_i);
    #1 chk("rdata", e, sfr_rdata_o);
  endtask
  // bounded wait for a register to reach a value, then one compare
  task automatic poll(input logic [7:0] a, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    @(posedge ref_clk_i);
    #1;
    while (sfr_rdata_o !== e && n < 4000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    last_wait = n;
    chk("polled", e, sfr_rdata_o);
  endtask
  task automatic warm();
    @(posedge ref_clk_i);
    warm_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    warm_rst_i <= 1'b0;
  endtask
  // unlock, load one tick before the hour carry (a rollover only with day-wrap set), relock
  task automatic preset(input logic [7:0] cfg);
    wr(8'hc1, 8'hea);
    wr(8'ha1, cfg);
    wr(8'ha5, 8'h17);
    wr(8'ha4, 8'h3b);
    wr(8'ha3, 8'h3b);
    wr(8'ha2, 8'h7f);
    wr(8'hc1, 8'h00);
  endtask
  // ***************************************************
  // hang guard and main sequence
  // ***************************************************
  // ceiling well above the ~7700 cycles the sequence needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(8'ha1, 8'h01);
    rd(8'hc1, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'ha5, 8'h05);
    rd(8'ha5, 8'h00);
    wr(8'hc1, 8'h55);
    wr(8'ha5, 8'h05);
    wr(8'hff, 8'h80);
    rd(8'ha5, 8'h00);
    chk("irqcfg", 8'h00, irq_pin_config_o);
    preset(8'h40);
    wr(8'hc1, 8'hea);
    wr(8'hff, 8'h80);
    wr(8'hc1, 8'h00);
    rd(8'hff, 8'h80);
    chk("irqcfg", 8'h80, irq_pin_config_o);
    poll(8'ha1, 8'hc1);
    chk("midnight", 8'h01, {7'h00, midnight_o});
    rd(8'ha5, 8'h00);
    rd(8'ha4, 8'h00);
    rd(8'ha3, 8'h00);
    rd(8'ha2, 8'h00);
    chk("sleepblk", 8'h01, {7'h00, deep_sleep_block_o});
    warm();
    rd(8'ha1, 8'hc1);
    wr(8'ha1, 8'h40);
    rd(8'ha1, 8'h41);
    chk("sleepblk", 8'h00, {7'h00, deep_sleep_block_o});
    chk("midnight", 8'h00, {7'h00, midnight_o});
    preset(8'h00);
    poll(8'ha5, 8'h18);
    rd(8'ha1, 8'h01);
    wr(8'ha6, 8'h02);
    wr(8'ha1, 8'h02);
    poll(8'ha1, 8'h07);
    chk("alarm", 8'h01, {7'h00, alarm_o});
    warm();
    repeat (2) @(posedge ref_clk_i);
    #1 chk("alarm", 8'h00, {7'h00, alarm_o});
    rd(8'ha1, 8'h01);
    rd(8'ha5, 8'h18);
    // hour timebase in 24-hour mode: a bare second carry must not fire, the hour carry must
    wr(8'ha6, 8'h01);
    wr(8'ha1, 8'h72);
    wr(8'hc1, 8'hea);
    wr(8'ha2, 8'h7f);
    wr(8'hc1, 8'h00);
    poll(8'ha2, 8'h00);
    rd(8'ha1, 8'h73);
    wr(8'hc1, 8'hea);
    wr(8'ha4, 8'h3b);
    wr(8'ha3, 8'h3b);
    wr(8'ha2, 8'h7f);
    wr(8'hc1, 8'h00);
    poll(8'ha1, 8'h77);
    rd(8'ha5, 8'h19);
    // trims add up to +128 crystal edges, so the last sub-second period is about half as long
    wr(8'hf6, 8'h40);
    wr(8'hf7, 8'h40);
    rd(8'hf6, 8'h40);
    rd(8'hf7, 8'h40);
    wr(8'hc1, 8'hea);
    wr(8'ha2, 8'h7e);
    wr(8'hc1, 8'h00);
    poll(8'ha2, 8'h7f);
    poll(8'ha2, 8'h00);
    chk("short_period", 8'h01, (last_wait > 400 && last_wait < 600) ? 8'h01 : 8'h00);
    // only power-on reset clears the time and the day-wrap bit
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(8'ha5, 8'h00);
    rd(8'ha1, 8'h01);
    results();
  end
endmodule // rtc_timekeeper_tb
`default_nettype wire

// ### test/rtc_xtal_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// crystal source, sped up: one 128 hz tick per ~1024 core cycles
// ***************************************************
module rtc_xtal_model #(
  parameter int HALF = 2
) (
  // core clock and start gate
  input wire logic ref_clk_i,
  input wire logic run_i,
  // crystal waveform
  output wire logic xtal_o
);
  int cnt_q = 0;
  logic xtal_q = 1'b0;
  assign xtal_o = xtal_q;
  // square wave that runs only while run_i is high and pauses whenever the reset tied to run_i is asserted
  always @(posedge ref_clk_i) begin
    if (run_i) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1) begin
        xtal_q <= ~xtal_q;
      end
    end
  end
endmodule // rtc_xtal_model
`default_nettype wire
